// ---- rtl/endpoint_flag_bank.sv ----
`default_nettype none

module endpoint_flag_bank (
	input  wire logic        clk_in,    // Core clock
	input  wire logic        reset_in,  // Sync reset, active high
	input  wire logic [11:0] set_in,    // Per-endpoint event pulses
	input  wire logic        clear_in,  // Register read clears all
	output logic      [11:0] flags_out  // Sticky flags
);
	// ==========================================================
	// One sticky flag per endpoint
	genvar i;
	generate
		for (i = 0; i < 12; i++) begin : g_flag
			logic flag_reg;   // Stored flag
			logic flag_next;  // Next value

			// Set wins over a read in the same cycle
			always_comb begin
				flag_next = set_in[i] | (flag_reg & ~clear_in);
			end

			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					flag_reg <= 1'b0;
				end else begin
					flag_reg <= flag_next;
				end
			end

			assign flags_out[i] = flag_reg;
		end
	endgenerate
endmodule : endpoint_flag_bank

`default_nettype wire

// ---- rtl/usb_core_defs.svh ----
`ifndef USB_CORE_DEFS_SVH
`define USB_CORE_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses on the register port)
`define OFS_DEVICE_ADDRESS      8'h00
`define OFS_POWER_MANAGEMENT    8'h01
`define OFS_IN_IRQ_FLAGS        8'h02
`define OFS_OUT_IRQ_FLAGS       8'h04
`define OFS_IN_IRQ_ENABLE       8'h06
`define OFS_OUT_IRQ_ENABLE      8'h08
`define OFS_SIGNAL_FLAGS        8'h0a
`define OFS_FRAME_NUMBER        8'h0c
`define OFS_ENDPOINT_SELECT     8'h0e
`define OFS_IN_CONTROL_LOW      8'h12
`define OFS_OUT_BYTE_COUNT      8'h18
`define OFS_FIFO_FIRST          8'h20
`define OFS_FIFO_LAST           8'h4c

// ==========================================================
// Field positions
`define ADDR_PENDING_BIT        7
`define PWR_ISO_UPDATE_BIT      7
`define PWR_SOFT_CONNECT_BIT    6
`define PWR_HS_ALLOW_BIT        5
`define PWR_HS_ACTIVE_BIT       4
`define PWR_BUS_RESET_BIT       3
`define PWR_RESUME_BIT          2
`define PWR_SUSPENDED_BIT       1
`define PWR_SUSPEND_EN_BIT      0
`define SIG_RESET_BIT           2
`define SIG_RESUME_BIT          1

// ==========================================================
// Reset values
`define RST_POWER_MANAGEMENT    8'h20
`define RST_IN_IRQ_ENABLE       12'h000
`define RST_OUT_IRQ_ENABLE      12'hffe
`define OUT_FLAG_MASK           12'hffe

// ==========================================================
// Timing
`define CLK_PERIOD_NS           40
`define SUSPEND_IDLE_NS         3000000

`endif

// ---- rtl/usb_core_pkg.sv ----
`default_nettype none

package usb_core_pkg;
	// ==========================================================
	// Link power state
	typedef enum logic {
		link_active,
		link_suspended
	} link_state_t;

	// One flag per endpoint 0..11
	typedef logic [11:0] endpoint_bits_t;
endpackage : usb_core_pkg

`default_nettype wire

// ---- rtl/usb_hs_device_core_control.sv ----
`include "usb_core_defs.svh"
`default_nettype none

// Overview of operation
// - Address write pends until transfer ends
// - Iso update: send after SOF, else zero
// - Soft connect drives or floats D+/D-
// - High-speed allow bit steers speed negotiation
// - Read-only bit shows high-speed operation
// - Read-only bit shows bus reset present
// - Resume bit drives resume signalling
// - Suspended bit clears on wake or resume
// - IN flags per endpoint, cleared on read
// - OUT flags endpoints 1-11, bit0 zero
// - IN and OUT enables gate endpoint interrupts
// - Endpoint zero overlays indexed window offsets
// - Per-endpoint FIFO ports four bytes apart
// - Index field selects windowed endpoint
// - Frame register holds last SOF number
// - Resume seen while suspended sets flag
module usb_hs_device_core_control #(
	parameter int SUSPEND_IDLE_CYCLES = `SUSPEND_IDLE_NS / `CLK_PERIOD_NS
) (
	input  wire logic        clk_in,             // Core clock, 25 MHz
	input  wire logic        reset_in,           // Sync reset, active high
	input  wire logic [7:0]  reg_addr_in,        // Register byte offset
	input  wire logic        reg_write_in,       // Write strobe
	input  wire logic        reg_read_in,        // Read strobe
	input  wire logic [15:0] reg_wdata_in,       // Write data
	input  wire logic [15:0] fifo_rdata_in,      // Data from selected FIFO
	input  wire logic        sof_in,             // SOF token received
	input  wire logic [10:0] sof_frame_in,       // Frame number in SOF
	input  wire logic        in_token_in,        // IN token received
	input  wire logic        iso_mode_in,        // Endpoint is isochronous
	input  wire logic        in_packet_ready_in, // Packet waiting in IN FIFO
	input  wire logic        transfer_done_in,   // Current transfer ended
	input  wire logic        bus_reset_in,       // Reset state on bus
	input  wire logic        hs_handshake_in,    // Host answered chirp
	input  wire logic        bus_activity_in,    // Any bus activity
	input  wire logic        resume_seen_in,     // Resume signalling seen
	input  wire logic [11:0] in_event_in,        // IN endpoint events
	input  wire logic [11:0] out_event_in,       // OUT endpoint events
	output logic [15:0]      reg_rdata_out,      // Read data, one cycle late
	output logic [6:0]       dev_addr_out,       // Address in use
	output logic             line_enable_out,    // D+/D- driver enable
	output logic             hs_negotiate_out,   // Attempt high-speed chirp
	output logic             resume_drive_out,   // Drive resume on bus
	output logic             suspend_out,        // Low-power suspend
	output logic             in_send_packet_out, // Send ready IN packet
	output logic             in_send_zero_out,   // Send zero-length packet
	output logic             csr_access_out,     // Window access pulse
	output logic             csr_ep_zero_out,    // Window maps endpoint zero
	output logic [4:0]       csr_ep_out,         // Windowed endpoint
	output logic [7:0]       csr_offset_out,     // Window offset accessed
	output logic             fifo_strobe_out,    // FIFO port access pulse
	output logic             fifo_write_out,     // FIFO access is a write
	output logic [3:0]       fifo_ep_out,        // FIFO endpoint
	output logic [15:0]      fifo_wdata_out,     // FIFO write data
	output logic             irq_out             // Endpoint interrupt
);
	// ==========================================================
	// Decode
	logic wr_addr, wr_power, rd_in_flags, rd_out_flags, rd_sig;
	logic fifo_hit;  // Offset is a FIFO port: in range and four-byte aligned
	always_comb begin
		wr_addr      = reg_write_in && reg_addr_in == `OFS_DEVICE_ADDRESS;
		wr_power     = reg_write_in && reg_addr_in == `OFS_POWER_MANAGEMENT;
		rd_in_flags  = reg_read_in && reg_addr_in == `OFS_IN_IRQ_FLAGS;
		rd_out_flags = reg_read_in && reg_addr_in == `OFS_OUT_IRQ_FLAGS;
		rd_sig       = reg_read_in && reg_addr_in == `OFS_SIGNAL_FLAGS;
		fifo_hit     = reg_addr_in >= `OFS_FIFO_FIRST && reg_addr_in <= `OFS_FIFO_LAST
			&& reg_addr_in[1:0] == 2'h0;
	end

	// ==========================================================
	// Endpoint flags, read clears
	usb_core_pkg::endpoint_bits_t in_flags, out_flags;
	endpoint_flag_bank u_in_flags (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.set_in   (in_event_in),
		.clear_in (rd_in_flags),
		.flags_out(in_flags)
	);
	endpoint_flag_bank u_out_flags (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.set_in   (out_event_in & `OUT_FLAG_MASK),
		.clear_in (rd_out_flags),
		.flags_out(out_flags)
	);

	// ==========================================================
	// Control registers
	logic [6:0]  addr_pend_reg, addr_pend_next;   // Address written by software
	logic        pending_reg, pending_next;       // Update not yet applied
	logic [6:0]  addr_reg, addr_next;             // Address in use
	logic [7:0]  power_reg, power_next;           // Writable power bits
	logic [11:0] in_en_reg, in_en_next;           // IN interrupt enables
	logic [11:0] out_en_reg, out_en_next;         // OUT interrupt enables
	logic [4:0]  sel_reg, sel_next;               // Endpoint select
	logic [10:0] frame_reg, frame_next;           // Last SOF frame
	logic        hs_reg, hs_next;                 // High-speed active
	logic        sig_reset_reg, sig_reset_next;   // Reset seen flag
	logic        sig_resume_reg, sig_resume_next; // Resume seen flag
	usb_core_pkg::link_state_t link_reg, link_next; // Power state, read by the resume flag above

	// Register writes and hardware-updated fields
	always_comb begin
		addr_pend_next  = addr_pend_reg;
		pending_next    = pending_reg;
		addr_next       = addr_reg;
		power_next      = power_reg;
		in_en_next      = in_en_reg;
		out_en_next     = out_en_reg;
		sel_next        = sel_reg;
		frame_next      = frame_reg;
		hs_next         = hs_reg;
		sig_reset_next  = sig_reset_reg & ~rd_sig;
		sig_resume_next = sig_resume_reg & ~rd_sig;
		// Apply at end of transfer; a new write in that cycle stays pending
		if (pending_reg && transfer_done_in) begin
			addr_next    = addr_pend_reg;
			pending_next = 1'b0;
		end
		if (wr_addr) begin
			addr_pend_next = reg_wdata_in[6:0];
			pending_next   = 1'b1;
		end
		if (wr_power) begin
			power_next = reg_wdata_in[7:0];
		end
		if (reg_write_in && reg_addr_in == `OFS_IN_IRQ_ENABLE) begin
			in_en_next = reg_wdata_in[11:0];
		end
		if (reg_write_in && reg_addr_in == `OFS_OUT_IRQ_ENABLE) begin
			out_en_next = reg_wdata_in[11:0] & `OUT_FLAG_MASK;
		end
		if (reg_write_in && reg_addr_in == `OFS_ENDPOINT_SELECT) begin
			sel_next = reg_wdata_in[4:0];
		end
		if (sof_in) begin
			frame_next = sof_frame_in;
		end
		// Speed settles during bus reset; disconnect drops it
		if (bus_reset_in) begin
			hs_next = power_reg[`PWR_HS_ALLOW_BIT] & hs_handshake_in;
		end
		if (!power_reg[`PWR_SOFT_CONNECT_BIT]) begin
			hs_next = 1'b0;
		end
		if (bus_reset_in) begin
			sig_reset_next = 1'b1;
		end
		if (resume_seen_in && link_reg == usb_core_pkg::link_suspended) begin
			sig_resume_next = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			addr_pend_reg  <= 7'h00;
			pending_reg    <= 1'b0;
			addr_reg       <= 7'h00;
			power_reg      <= `RST_POWER_MANAGEMENT;
			in_en_reg      <= `RST_IN_IRQ_ENABLE;
			out_en_reg     <= `RST_OUT_IRQ_ENABLE;
			sel_reg        <= 5'h00;
			frame_reg      <= 11'h000;
			hs_reg         <= 1'b0;
			sig_reset_reg  <= 1'b0;
			sig_resume_reg <= 1'b0;
		end else begin
			addr_pend_reg  <= addr_pend_next;
			pending_reg    <= pending_next;
			addr_reg       <= addr_next;
			power_reg      <= power_next;
			in_en_reg      <= in_en_next;
			out_en_reg     <= out_en_next;
			sel_reg        <= sel_next;
			frame_reg      <= frame_next;
			hs_reg         <= hs_next;
			sig_reset_reg  <= sig_reset_next;
			sig_resume_reg <= sig_resume_next;
		end
	end

	// ==========================================================
	// Suspend state machine
	logic [16:0] idle_reg, idle_next;                // Idle cycle count
	// Strictly more than the idle time before suspending
	always_comb begin
		link_next = link_reg;
		idle_next = idle_reg;
		case (link_reg)
			usb_core_pkg::link_active: begin
				// Our own resume signalling counts as activity, so no re-suspend
				if (bus_activity_in || power_reg[`PWR_RESUME_BIT]
					|| !power_reg[`PWR_SUSPEND_EN_BIT]) begin
					idle_next = 17'h00000;
				end else if (idle_reg > 17'(SUSPEND_IDLE_CYCLES)) begin
					link_next = usb_core_pkg::link_suspended;
				end else begin
					idle_next = idle_reg + 17'h00001;
				end
			end
			usb_core_pkg::link_suspended: begin
				idle_next = 17'h00000;
				// Wake on host activity or our own resume
				if (power_reg[`PWR_RESUME_BIT] || bus_activity_in || resume_seen_in
					|| !power_reg[`PWR_SUSPEND_EN_BIT]) begin
					link_next = usb_core_pkg::link_active;
				end
			end
			default: begin
				link_next = usb_core_pkg::link_active;
				idle_next = 17'h00000;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			link_reg <= usb_core_pkg::link_active;
			idle_reg <= 17'h00000;
		end else begin
			link_reg <= link_next;
			idle_reg <= idle_next;
		end
	end

	// ==========================================================
	// Isochronous update: SOF arms one packet per frame
	logic sof_armed_reg, sof_armed_next;  // SOF since last IN
	logic send_pkt_next, send_zero_next;  // IN answer
	always_comb begin
		sof_armed_next = sof_armed_reg | sof_in;
		send_pkt_next  = 1'b0;
		send_zero_next = 1'b0;
		if (in_token_in) begin
			sof_armed_next = 1'b0;
			if (iso_mode_in && power_reg[`PWR_ISO_UPDATE_BIT]) begin
				send_pkt_next  = sof_armed_reg & in_packet_ready_in;
				send_zero_next = ~(sof_armed_reg & in_packet_ready_in);
			end else begin
				send_pkt_next = in_packet_ready_in;
			end
		end
	end

	// ==========================================================
	// Outputs, read data and access strobes
	logic [15:0] rdata_next;  // Read mux
	always_comb begin
		rdata_next = 16'h0000;
		case (reg_addr_in)
			`OFS_DEVICE_ADDRESS:   rdata_next = {8'h00, pending_reg, addr_pend_reg};
			`OFS_POWER_MANAGEMENT: begin
				rdata_next = {8'h00, power_reg};
				rdata_next[`PWR_HS_ACTIVE_BIT] = hs_reg;
				rdata_next[`PWR_BUS_RESET_BIT] = bus_reset_in;
				rdata_next[`PWR_SUSPENDED_BIT] =
					link_reg == usb_core_pkg::link_suspended;
			end
			`OFS_IN_IRQ_FLAGS:     rdata_next = {4'h0, in_flags};
			`OFS_OUT_IRQ_FLAGS:    rdata_next = {4'h0, out_flags};
			`OFS_IN_IRQ_ENABLE:    rdata_next = {4'h0, in_en_reg};
			`OFS_OUT_IRQ_ENABLE:   rdata_next = {4'h0, out_en_reg};
			`OFS_SIGNAL_FLAGS:     rdata_next = {13'h0000, sig_reset_reg, sig_resume_reg, 1'b0};
			`OFS_FRAME_NUMBER:     rdata_next = {5'h00, frame_reg};
			`OFS_ENDPOINT_SELECT:  rdata_next = {11'h000, sel_reg};
			default: begin
				if (fifo_hit) begin
					rdata_next = fifo_rdata_in;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			reg_rdata_out      <= 16'h0000;
			dev_addr_out       <= 7'h00;
			line_enable_out    <= 1'b0;
			hs_negotiate_out   <= 1'b0;
			resume_drive_out   <= 1'b0;
			suspend_out        <= 1'b0;
			sof_armed_reg      <= 1'b0;
			in_send_packet_out <= 1'b0;
			in_send_zero_out   <= 1'b0;
			csr_access_out     <= 1'b0;
			csr_ep_zero_out    <= 1'b0;
			csr_ep_out         <= 5'h00;
			csr_offset_out     <= 8'h00;
			fifo_strobe_out    <= 1'b0;
			fifo_write_out     <= 1'b0;
			fifo_ep_out        <= 4'h0;
			fifo_wdata_out     <= 16'h0000;
			irq_out            <= 1'b0;
		end else begin
			reg_rdata_out      <= reg_read_in ? rdata_next : 16'h0000;
			dev_addr_out       <= addr_next;
			line_enable_out    <= power_next[`PWR_SOFT_CONNECT_BIT];
			hs_negotiate_out   <= power_next[`PWR_HS_ALLOW_BIT];
			resume_drive_out   <= power_next[`PWR_RESUME_BIT];
			suspend_out        <= link_next == usb_core_pkg::link_suspended;
			sof_armed_reg      <= sof_armed_next;
			in_send_packet_out <= send_pkt_next;
			in_send_zero_out   <= send_zero_next;
			// Shared window: endpoint zero control and count at index 0
			csr_access_out     <= (reg_read_in | reg_write_in)
				&& (reg_addr_in == `OFS_IN_CONTROL_LOW
				|| reg_addr_in == `OFS_OUT_BYTE_COUNT);
			csr_ep_zero_out    <= sel_reg == 5'h00;
			csr_ep_out         <= sel_reg;
			csr_offset_out     <= reg_addr_in;
			fifo_strobe_out    <= (reg_read_in | reg_write_in) & fifo_hit;
			fifo_write_out     <= reg_write_in;
			fifo_ep_out        <= 4'((reg_addr_in - `OFS_FIFO_FIRST) >> 2);
			fifo_wdata_out     <= reg_wdata_in;
			irq_out            <= |((in_flags & in_en_reg) | (out_flags & out_en_reg));
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_addr_write;
		wr_addr && !(pending_reg && transfer_done_in);
	endsequence
	sequence s_addr_apply;
		pending_reg && transfer_done_in && !wr_addr;
	endsequence

	property p_addr_pending;
		s_addr_write |=> pending_reg && dev_addr_out == $past(dev_addr_out);
	endproperty
	a_addr_pending: assert property (p_addr_pending) else $error("address not pending");

	property p_addr_apply;
		s_addr_apply |=> !pending_reg && dev_addr_out == $past(addr_pend_reg);
	endproperty
	a_addr_apply: assert property (p_addr_apply) else $error("address not applied");

	property p_iso_zero;
		in_token_in && iso_mode_in && power_reg[`PWR_ISO_UPDATE_BIT] && !sof_armed_reg
			|=> in_send_zero_out && !in_send_packet_out;
	endproperty
	a_iso_zero: assert property (p_iso_zero) else $error("no zero packet before SOF");

	property p_softconn;
		wr_power |=> line_enable_out == $past(reg_wdata_in[`PWR_SOFT_CONNECT_BIT]);
	endproperty
	a_softconn: assert property (p_softconn) else $error("line enable mismatch");

	property p_fs_only;
		bus_reset_in && !power_reg[`PWR_HS_ALLOW_BIT] |=> !hs_reg;
	endproperty
	a_fs_only: assert property (p_fs_only) else $error("high speed while not allowed");

	property p_resume_wakes;
		power_reg[`PWR_RESUME_BIT] ##1 power_reg[`PWR_RESUME_BIT] |=> !suspend_out;
	endproperty
	a_resume_wakes: assert property (p_resume_wakes) else $error("suspended during resume");

	property p_no_suspend;
		!power_reg[`PWR_SUSPEND_EN_BIT] |=> !suspend_out;
	endproperty
	a_no_suspend: assert property (p_no_suspend) else $error("suspend while disabled");

	property p_in_flag;
		in_event_in[0] |=> in_flags[0];
	endproperty
	a_in_flag: assert property (p_in_flag) else $error("IN flag lost");

	property p_out_reserved;
		out_event_in[0] |=> !out_flags[0];
	endproperty
	a_out_reserved: assert property (p_out_reserved) else $error("OUT bit0 set");

	property p_irq;
		|(in_flags & in_en_reg) |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule : usb_hs_device_core_control

`default_nettype wire

// ---- test/host_bus_model.sv ----
`default_nettype none

// ==========================================================
// Host stand-in: tokens, SOF, bus states, endpoint events
module host_bus_model (
	input  wire logic        clk_in,     // Core clock
	input  wire logic        pkt_in,     // Device sends packet
	input  wire logic        zlp_in,     // Device sends zero packet
	output logic             sof_out,    // SOF pulse
	output logic [10:0]      frame_out,  // SOF frame number
	output logic             token_out,  // IN token pulse
	output logic             done_out,   // Transfer end pulse
	output logic             rst_out,    // Reset state on bus
	output logic             chirp_out,  // Chirp answered
	output logic             act_out,    // Bus activity
	output logic             wake_out,   // Resume seen pulse
	output logic [11:0]      in_ev_out,  // IN endpoint events
	output logic [11:0]      out_ev_out  // OUT endpoint events
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet bus at time zero
	initial begin
		{sof_out, token_out, done_out, rst_out, chirp_out, act_out, wake_out} = 7'h00;
		frame_out = 11'h000;
		in_ev_out = 12'h000;
		out_ev_out = 12'h000;
	end

	// One-cycle pulse: SOF, transfer end, activity, resume
	task automatic pulse(input logic [3:0] w, input logic [10:0] f);
		@(negedge clk_in);
		{sof_out, done_out, act_out, wake_out} = w;
		frame_out = f;
		@(negedge clk_in);
		{sof_out, done_out, act_out, wake_out} = 4'h0;
		frame_out = ~f; // Stale frame must not look valid
	endtask : pulse

	// Bus reset state and chirp answer, held as levels
	task automatic bus(input logic r, input logic c);
		@(negedge clk_in);
		rst_out = r;
		chirp_out = c;
	endtask : bus

	// Endpoint activity, one cycle
	task automatic events(input logic [11:0] i, input logic [11:0] o);
		@(negedge clk_in);
		in_ev_out = i;
		out_ev_out = o;
		@(negedge clk_in);
		in_ev_out = 12'h000;
		out_ev_out = 12'h000;
	endtask : events

	// IN token; the answer stands the cycle after
	task automatic token(output logic [1:0] ans);
		@(negedge clk_in);
		token_out = 1'b1;
		@(negedge clk_in);
		token_out = 1'b0;
		ans = {pkt_in, zlp_in};
	endtask : token
endmodule : host_bus_model

`default_nettype wire

// ---- test/usb_hs_device_core_control_tb.sv ----
`default_nettype none

module usb_hs_device_core_control_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Stimulus, design outputs, host wiring
	logic        clk_in = 1'b0;    // 25 MHz core clock
	logic        reset_in = 1'b1;  // Sync reset
	logic [7:0]  addr = 8'h00;     // Register offset
	logic        wr = 1'b0;        // Write strobe
	logic        rd = 1'b0;        // Read strobe
	logic [15:0] wdata = 16'h0000; // Write data
	logic [15:0] fdata = 16'h0000; // FIFO read data
	logic        iso = 1'b0;       // Endpoint is isochronous
	logic        ready = 1'b0;     // Packet waiting
	logic [15:0] rdata, q, f_wd;   // Read data, capture
	logic [6:0]  dev_addr;         // Address in use
	logic [4:0]  csr_ep;           // Windowed endpoint
	logic [7:0]  csr_ofs;          // Window offset
	logic [3:0]  f_ep;             // FIFO endpoint
	logic [10:0] frame;            // SOF frame
	logic [11:0] in_ev, out_ev;    // Endpoint events
	logic [1:0]  ans;              // IN answer
	logic line_en, hs_neg, res_drv, susp, pkt, zlp, csr_acc, csr_z, f_stb, f_wr, irq;
	logic sof, tok, done, brst, chirp, act, wake;
	int   failures = 0;            // Mismatches
	int   tests_run = 0;           // Comparisons
	int   cyc = 0;                 // Cycle count for timeout

	// Idle count shortened so suspend is reached quickly
	usb_hs_device_core_control #(.SUSPEND_IDLE_CYCLES(20)) usb_hs_device_core_control_inst (
		.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_write_in(wr),
		.reg_read_in(rd), .reg_wdata_in(wdata), .fifo_rdata_in(fdata), .sof_in(sof),
		.sof_frame_in(frame), .in_token_in(tok), .iso_mode_in(iso),
		.in_packet_ready_in(ready), .transfer_done_in(done), .bus_reset_in(brst),
		.hs_handshake_in(chirp), .bus_activity_in(act), .resume_seen_in(wake),
		.in_event_in(in_ev), .out_event_in(out_ev), .reg_rdata_out(rdata),
		.dev_addr_out(dev_addr), .line_enable_out(line_en), .hs_negotiate_out(hs_neg),
		.resume_drive_out(res_drv), .suspend_out(susp), .in_send_packet_out(pkt),
		.in_send_zero_out(zlp), .csr_access_out(csr_acc), .csr_ep_zero_out(csr_z),
		.csr_ep_out(csr_ep), .csr_offset_out(csr_ofs), .fifo_strobe_out(f_stb),
		.fifo_write_out(f_wr), .fifo_ep_out(f_ep), .fifo_wdata_out(f_wd), .irq_out(irq));

	host_bus_model host_bus_model_inst (
		.clk_in(clk_in), .pkt_in(pkt), .zlp_in(zlp), .sof_out(sof), .frame_out(frame),
		.token_out(tok), .done_out(done), .rst_out(brst), .chirp_out(chirp),
		.act_out(act), .wake_out(wake), .in_ev_out(in_ev), .out_ev_out(out_ev));

	always #20 clk_in = ~clk_in;

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			wrap_up();
		end
	end

	// ==========================================================
	// Bench tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One access; read data stands the cycle after the strobe
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_in);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(negedge clk_in);
		wr = 1'b0;
		rd = 1'b0;
		q = rdata;
	endtask : acc

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		acc(1'b0, a, 16'h0000);
		chk(q, exp);
	endtask : rchk

	task automatic idle(input int n);
		repeat (n) @(negedge clk_in);
	endtask : idle

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// ==========================================================
	// Test sequence
	initial begin
		repeat (3) @(negedge clk_in);
		reset_in = 1'b0;
		idle(2);
		chk(hs_neg, 16'h0001);
		rchk(8'h01, 16'h0020);
		rchk(8'h06, 16'h0000);
		rchk(8'h10, 16'h0000);
		$display("test reset done");
		// New address pends until the transfer ends
		acc(1'b1, 8'h00, 16'h002a);
		rchk(8'h00, 16'h00aa);
		chk(dev_addr, 16'h0000);
		host_bus_model_inst.pulse(4'h4, 11'h000);
		idle(1);
		chk(dev_addr, 16'h002a);
		rchk(8'h00, 16'h002a);
		$display("test address done");
		// Connect, speed and bus reset status
		acc(1'b1, 8'h01, 16'h0040);
		idle(1);
		chk({line_en, hs_neg}, 16'h0002);
		acc(1'b1, 8'h01, 16'h0060);
		host_bus_model_inst.bus(1'b1, 1'b1);
		idle(2);
		rchk(8'h01, 16'h0078);
		host_bus_model_inst.bus(1'b0, 1'b1);
		idle(1);
		rchk(8'h01, 16'h0070);
		rchk(8'h0a, 16'h0004);
		idle(30);
		chk(susp, 16'h0000);
		// Suspend, activity, resume bit, resume seen
		acc(1'b1, 8'h01, 16'h0061);
		idle(12);
		host_bus_model_inst.pulse(4'h2, 11'h000);
		idle(12);
		chk(susp, 16'h0000);
		idle(12);
		chk(susp, 16'h0001);
		rchk(8'h01, 16'h0073);
		acc(1'b1, 8'h01, 16'h0065);
		rchk(8'h01, 16'h0075);
		chk({res_drv, susp}, 16'h0002);
		// Resume hold cut far below the real window to keep the run short
		acc(1'b1, 8'h01, 16'h0061);
		idle(30);
		host_bus_model_inst.pulse(4'h1, 11'h000);
		idle(1);
		chk(susp, 16'h0000);
		acc(1'b1, 8'h01, 16'h0060);
		rchk(8'h0a, 16'h0002);
		// Bus reset with high speed barred settles at full speed
		acc(1'b1, 8'h01, 16'h0040);
		host_bus_model_inst.bus(1'b1, 1'b1);
		idle(2);
		rchk(8'h01, 16'h0048);
		host_bus_model_inst.bus(1'b0, 1'b0);
		$display("test power done");
		// Flags, enables and the interrupt line
		acc(1'b1, 8'h08, 16'h0000);
		host_bus_model_inst.events(12'h801, 12'hfff);
		idle(1);
		chk(irq, 16'h0000);
		acc(1'b1, 8'h06, 16'h0001);
		idle(1);
		chk(irq, 16'h0001);
		rchk(8'h06, 16'h0001);
		rchk(8'h02, 16'h0801);
		rchk(8'h02, 16'h0000);
		rchk(8'h04, 16'h0ffe);
		rchk(8'h04, 16'h0000);
		idle(1);
		chk(irq, 16'h0000);
		$display("test flags done");
		// Isochronous IN answers around SOF
		acc(1'b1, 8'h01, 16'h00e0);
		iso = 1'b1;
		ready = 1'b1;
		host_bus_model_inst.token(ans);
		chk(ans, 16'h0001);
		host_bus_model_inst.pulse(4'h8, 11'h5a5);
		host_bus_model_inst.token(ans);
		chk(ans, 16'h0002);
		host_bus_model_inst.token(ans);
		chk(ans, 16'h0001);
		iso = 1'b0;
		host_bus_model_inst.token(ans);
		chk(ans, 16'h0002);
		ready = 1'b0;
		host_bus_model_inst.token(ans);
		chk(ans, 16'h0000);
		rchk(8'h0c, 16'h05a5);
		$display("test iso done");
		// Endpoint window and FIFO ports
		acc(1'b1, 8'h0e, 16'h0000);
		acc(1'b1, 8'h12, 16'h0055);
		chk({csr_acc, csr_z, csr_ofs}, 16'h0312);
		acc(1'b1, 8'h0e, 16'h0005);
		rchk(8'h0e, 16'h0005);
		acc(1'b0, 8'h18, 16'h0000);
		chk({csr_acc, csr_z, csr_ep, csr_ofs}, 16'h4518);
		for (int i = 0; i < 12; i++) begin
			acc(1'b1, 8'(8'h20 + 4 * i), 16'(16'h1000 + i));
			chk({f_stb, f_wr, f_ep}, 16'(16'h0030 + i));
			chk(f_wd, 16'(16'h1000 + i));
		end
		fdata = 16'h1234;
		rchk(8'h2c, 16'h1234);
		chk({f_stb, f_wr, f_ep}, 16'h0023);
		rchk(8'h2e, 16'h0000);
		chk(f_stb, 16'h0000);
		$display("test window done");
		wrap_up();
	end
endmodule : usb_hs_device_core_control_tb

`default_nettype wire
